// [design/ces_top.v]
// CPU exception sequencer: reset, interrupt and trap entry with vector fetch.
// Assumes a memory port that acknowledges with i_mem_ack, an instruction
// sequencer that flags instruction ends and traps, and software on the
// plain register port.
//
// Summary of operation
// - Pending exceptions taken: reset, interrupt, trap.
// - Trap always accepted while running, never masked.
// - Interrupts wait for instruction or entry end.
// - Trap/interrupt: push PC and flags, mask, vector.
// - Reset entry: no push, mask, reset vector.
// - Vector slot address is four times number.
// - Trap selector 0-3 maps to vectors 8-11.
// - Init pin low halts the sequencer and initialises its state and registers.
// - Reset handling starts on init pin rising.
// - Leaving reset sets global mask, reads vector.
// - Watchdog overflow in reset mode resets too.
// - No interrupt before first instruction completes.
// - Nonmaskable interrupt highest, ignores mask flags.
// - Maskable sources on two levels, arbitrated.
// - Trap sets global mask; aux too if select 0.
// - Eight external plus 34 internal vectored sources.
// - Eight address areas, 1M or 16M mode.
// - Memory enable clear sends RAM range external.
// - Flag select bit 3, resets to 1.
// - Edge select bit 2: 0 falling, 1 rising.
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ces_defines.vh"

module ces_top #(
    parameter N_EXT  = 8,
    parameter N_INT  = 34,
    parameter RAM_LO_1M  = 24'h0fef10,
    parameter RAM_HI_1M  = 24'h0fff0f,
    parameter RAM_LO_16M = 24'hffef10,
    parameter RAM_HI_16M = 24'hffff0f
) (
    // Clock and reset
    input  wire                     i_clk,
    input  wire                     i_rst,
    // Pins
    input  wire                     i_chip_init_pin_n,
    input  wire                     i_nmi_pin,
    input  wire                     i_mode_16m_pin,
    // Watchdog
    input  wire                     i_watchdog_unit_ovf,
    input  wire                     i_watchdog_unit_rst_sel,
    // Interrupt requests from the controller, external lines first
    input  wire [N_EXT+N_INT-1:0]   i_irq_req,
    // Instruction sequencer
    input  wire                     i_insn_done,
    input  wire                     i_software_trap_instruction,
    input  wire [1:0]               i_trap_sel,
    input  wire [23:0]              i_pc,
    input  wire [7:0]               i_condition_flags_register,
    input  wire [23:0]              i_stack_top_pointer,
    // Memory port
    input  wire                     i_mem_ack,
    input  wire [31:0]              i_mem_rdata,
    output reg                      o_mem_rd,
    output reg                      o_mem_wr,
    output reg  [23:0]              o_mem_addr,
    output reg  [31:0]              o_mem_wdata,
    // Results to the CPU core
    output reg                      o_run,
    output reg                      o_periph_init,
    output reg                      o_pc_load,
    output reg  [23:0]              o_pc_new,
    output reg                      o_flags_load,
    output reg  [7:0]               o_flags_new,
    output reg                      o_sp_load,
    output reg  [23:0]              o_sp_new,
    output reg                      o_irq_ack,
    output reg  [5:0]               o_irq_ack_vec,
    // Address decode
    input  wire [23:0]              i_acc_addr,
    output reg  [2:0]               o_area,
    output reg                      o_ext_bus,
    // Register port
    input  wire [7:0]               i_reg_addr,
    input  wire [7:0]               i_reg_wdata,
    input  wire                     i_reg_wr,
    input  wire                     i_reg_rd,
    output reg  [7:0]               o_reg_rdata
);

    localparam NSRC = N_EXT + N_INT;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [2:0] ST_HOLD = 3'd0;
    localparam [2:0] ST_RVEC = 3'd1;
    localparam [2:0] ST_RUN  = 3'd2;
    localparam [2:0] ST_PUSH = 3'd3;
    localparam [2:0] ST_VEC  = 3'd4;

    reg [2:0]  state_r;
    reg [7:0]  system_control_reg_r;
    reg [7:0]  priority_level_reg_first_r;
    reg [7:0]  priority_level_reg_second_r;
    reg        nmi_pend_r;
    reg        trap_pend_r;
    reg [1:0]  trap_sel_r;
    reg        first_blk_r;
    reg        entry_done_r;
    reg [5:0]  vec_r;
    reg        wdt_hold_r;
    reg        mode_meta_r;
    reg        mode_16m_r;

    wire init_level;
    wire init_rise;
    wire nmi_edge;
    wire ufs = system_control_reg_r[`CES_SC_UFS_BIT];
    wire i_f = i_condition_flags_register[`CES_CCR_I_BIT];
    wire ui_f = i_condition_flags_register[`CES_CCR_UI_BIT];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    ces_pin_edge u_init (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_chip_init_pin_n),
        .i_rise_sel (1'b1),
        .o_level    (init_level),
        .o_edge     (init_rise)
    );

    ces_pin_edge u_nmi (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_pin      (i_nmi_pin),
        .i_rise_sel (system_control_reg_r[`CES_SC_NONMASKABLE_EDGE_SELECT_BIT]),
        .o_level    (),
        .o_edge     (nmi_edge)
    );

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_meta_r <= 1'b0;
            mode_16m_r  <= 1'b0;
        end else begin
            mode_meta_r <= i_mode_16m_pin;
            mode_16m_r  <= mode_meta_r;
        end
    end

    // Reset state: pin low, or watchdog overflow in reset mode
    wire wdt_reset = i_watchdog_unit_ovf & i_watchdog_unit_rst_sel;
    wire in_reset  = ~init_level | wdt_reset;

    // ------------------------------------------------------------
    // Interrupt arbitration
    // ------------------------------------------------------------
    reg [NSRC-1:0] lvl;
    reg            pick_ok;
    reg [5:0]      pick_idx;
    reg            lvl1_ok;
    reg            lvl0_ok;
    integer        s;

    // Level bit per source; internal sources share bits in groups of eight, the last two share bit 7 of the second register
    always @* begin
        lvl = {NSRC{1'b0}};
        for (s = 0; s < NSRC; s = s + 1) begin
            if (s == 0) begin
                lvl[s] = priority_level_reg_first_r[7];
            end else if (s == 1) begin
                lvl[s] = priority_level_reg_first_r[6];
            end else if (s < 4) begin
                lvl[s] = priority_level_reg_first_r[5];
            end else if (s < N_EXT) begin
                lvl[s] = priority_level_reg_first_r[4];
            end else if (s < N_EXT + 32) begin
                lvl[s] = priority_level_reg_first_r[3 - ((s - N_EXT) >> 3)];
            end else begin
                lvl[s] = priority_level_reg_second_r[7];
            end
        end
    end

    // Three-level masking when the aux flag is a mask, else I alone
    always @* begin
        lvl1_ok  = ~i_f;
        lvl0_ok  = ~i_f & (ufs | ~ui_f);
        pick_ok  = 1'b0;
        pick_idx = 6'h00;
        for (s = NSRC - 1; s >= 0; s = s - 1) begin
            if (i_irq_req[s] & ~lvl[s] & lvl0_ok & ~(|(i_irq_req & lvl))) begin
                pick_ok  = 1'b1;
                pick_idx = s[5:0];
            end
        end
        for (s = NSRC - 1; s >= 0; s = s - 1) begin
            if (i_irq_req[s] & lvl[s] & lvl1_ok) begin
                pick_ok  = 1'b1;
                pick_idx = s[5:0];
            end
        end
    end

    // Interrupts wait for a boundary and are shut out until the first
    // instruction after reset, since the stack pointer is not yet valid.
    wire boundary = (i_insn_done | entry_done_r) & ~first_blk_r;
    wire take_nmi = boundary & nmi_pend_r;
    wire take_irq = boundary & ~nmi_pend_r & pick_ok;
    wire trap_now = trap_pend_r | i_software_trap_instruction;

    // Flags for entry: aux mask joins only when it acts as a mask
    wire [7:0] flags_set = i_condition_flags_register
                         | (8'h01 << `CES_CCR_I_BIT)
                         | ({7'h00, ~ufs} << `CES_CCR_UI_BIT);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r       <= ST_HOLD;
            nmi_pend_r    <= 1'b0;
            trap_pend_r   <= 1'b0;
            trap_sel_r    <= 2'b00;
            first_blk_r   <= 1'b1;
            entry_done_r  <= 1'b0;
            vec_r         <= `CES_VEC_RESET;
            wdt_hold_r    <= 1'b0;
            o_mem_rd      <= 1'b0;
            o_mem_wr      <= 1'b0;
            o_mem_addr    <= 24'h000000;
            o_mem_wdata   <= 32'h00000000;
            o_run         <= 1'b0;
            o_periph_init <= 1'b1;
            o_pc_load     <= 1'b0;
            o_pc_new      <= 24'h000000;
            o_flags_load  <= 1'b0;
            o_flags_new   <= 8'h00;
            o_sp_load     <= 1'b0;
            o_sp_new      <= 24'h000000;
            o_irq_ack     <= 1'b0;
            o_irq_ack_vec <= 6'h00;
        end else begin
            o_pc_load    <= 1'b0;
            o_flags_load <= 1'b0;
            o_sp_load    <= 1'b0;
            o_irq_ack    <= 1'b0;
            entry_done_r <= 1'b0;
            wdt_hold_r   <= wdt_reset;
            // A new edge wins over the clear in the same cycle
            if (nmi_edge) begin
                nmi_pend_r <= 1'b1;
            end else if (take_nmi && state_r == ST_RUN) begin
                nmi_pend_r <= 1'b0;
            end
            if (i_insn_done) begin
                first_blk_r <= 1'b0;
            end
            if (in_reset) begin
                state_r       <= ST_HOLD;
                o_periph_init <= 1'b1;
                o_run         <= 1'b0;
                o_mem_rd      <= 1'b0;
                o_mem_wr      <= 1'b0;
                nmi_pend_r    <= 1'b0;
                trap_pend_r   <= 1'b0;
                first_blk_r   <= 1'b1;
            end else begin
                case (state_r)
                    ST_HOLD: begin
                        // Pin release or end of a watchdog reset
                        if (init_rise | wdt_hold_r) begin
                            state_r       <= ST_RVEC;
                            o_periph_init <= 1'b0;
                            o_mem_rd      <= 1'b1;
                            o_mem_addr    <= {16'h0000, `CES_VEC_RESET, 2'b00};
                        end
                    end
                    ST_RVEC: begin
                        if (i_mem_ack) begin
                            // No push: the stack pointer is undefined here
                            o_mem_rd     <= 1'b0;
                            o_pc_load    <= 1'b1;
                            o_pc_new     <= i_mem_rdata[23:0];
                            o_flags_load <= 1'b1;
                            o_flags_new  <= i_condition_flags_register
                                          | (8'h01 << `CES_CCR_I_BIT);
                            o_run        <= 1'b1;
                            state_r      <= ST_RUN;
                        end
                    end
                    ST_RUN: begin
                        if (i_software_trap_instruction) begin
                            trap_pend_r <= 1'b1;
                            trap_sel_r  <= i_trap_sel;
                        end
                        if (take_nmi | take_irq | trap_now) begin
                            if (take_nmi) begin
                                vec_r <= `CES_VEC_NMI;
                            end else if (take_irq) begin
                                vec_r <= `CES_VEC_SRC_BASE + pick_idx;
                            end else begin
                                // Trap is never masked
                                trap_pend_r <= 1'b0;
                                vec_r <= `CES_VEC_TRAP_BASE
                                       + {4'h0, (trap_pend_r ? trap_sel_r : i_trap_sel)};
                            end
                            o_irq_ack     <= take_nmi | take_irq;
                            o_irq_ack_vec <= take_nmi ? `CES_VEC_NMI
                                                      : `CES_VEC_SRC_BASE + pick_idx;
                            o_run       <= 1'b0;
                            state_r     <= ST_PUSH;
                            o_mem_wr    <= 1'b1;
                            // Even longword frame, low address bit forced to zero
                            o_mem_addr  <= (i_stack_top_pointer - `CES_FRAME_BYTES)
                                         & 24'hfffffe;
                            o_mem_wdata <= {i_condition_flags_register, i_pc};
                        end
                    end
                    ST_PUSH: begin
                        if (i_mem_ack) begin
                            o_mem_wr   <= 1'b0;
                            o_sp_load  <= 1'b1;
                            o_sp_new   <= o_mem_addr;
                            o_mem_rd   <= 1'b1;
                            o_mem_addr <= {16'h0000, vec_r, 2'b00};
                            state_r    <= ST_VEC;
                        end
                    end
                    ST_VEC: begin
                        if (i_mem_ack) begin
                            o_mem_rd     <= 1'b0;
                            o_pc_load    <= 1'b1;
                            o_pc_new     <= i_mem_rdata[23:0];
                            o_flags_load <= 1'b1;
                            o_flags_new  <= flags_set;
                            o_run        <= 1'b1;
                            entry_done_r <= 1'b1;
                            state_r      <= ST_RUN;
                        end
                    end
                    default: begin
                        state_r <= ST_HOLD;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            system_control_reg_r        <= `CES_SYSCTL_RST;
            priority_level_reg_first_r  <= `CES_PRIO_RST;
            priority_level_reg_second_r <= `CES_PRIO_RST;
            o_reg_rdata                 <= 8'h00;
        end else if (in_reset) begin
            system_control_reg_r        <= `CES_SYSCTL_RST;
            priority_level_reg_first_r  <= `CES_PRIO_RST;
            priority_level_reg_second_r <= `CES_PRIO_RST;
            o_reg_rdata                 <= 8'h00;
        end else begin
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `CES_OFS_SYSCTL: begin
                        // Bit 1 is fixed at one
                        system_control_reg_r <= i_reg_wdata
                                              | (8'h01 << `CES_SC_FIXED1_BIT);
                    end
                    `CES_OFS_PRIO_FIRST: begin
                        priority_level_reg_first_r <= i_reg_wdata;
                    end
                    `CES_OFS_PRIO_SECOND: begin
                        priority_level_reg_second_r <= i_reg_wdata;
                    end
                    default: begin
                    end
                endcase
            end
            case (i_reg_addr)
                `CES_OFS_SYSCTL: begin
                    o_reg_rdata <= i_reg_rd ? system_control_reg_r : 8'h00;
                end
                `CES_OFS_PRIO_FIRST: begin
                    o_reg_rdata <= i_reg_rd ? priority_level_reg_first_r : 8'h00;
                end
                `CES_OFS_PRIO_SECOND: begin
                    o_reg_rdata <= i_reg_rd ? priority_level_reg_second_r : 8'h00;
                end
                default: begin
                    o_reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire in_ram = mode_16m_r ? (i_acc_addr >= RAM_LO_16M && i_acc_addr <= RAM_HI_16M)
                             : (i_acc_addr >= RAM_LO_1M  && i_acc_addr <= RAM_HI_1M);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_area    <= 3'd0;
            o_ext_bus <= 1'b1;
        end else begin
            o_area    <= mode_16m_r ? i_acc_addr[23:21] : i_acc_addr[19:17];
            o_ext_bus <= ~(in_ram & system_control_reg_r[`CES_SC_ONCHIP_MEMORY_ENABLE_BIT]);
        end
    end

endmodule

`default_nettype wire

// [shared/ces_defines.vh]
// Constants for the CPU exception sequencer: register offsets, reset
// values, field positions and vector numbers.
// Assumes inclusion by bare name from the design files.
`ifndef CES_DEFINES_VH
`define CES_DEFINES_VH

// Register offsets on the plain register port
`define CES_OFS_SYSCTL      8'hf2
`define CES_OFS_PRIO_FIRST  8'hf8
`define CES_OFS_PRIO_SECOND 8'hf9

// Reset values
`define CES_SYSCTL_RST      8'h0b
`define CES_PRIO_RST        8'h00

// System control register fields
`define CES_SC_UFS_BIT      3
`define CES_SC_NONMASKABLE_EDGE_SELECT_BIT    2
`define CES_SC_FIXED1_BIT   1
`define CES_SC_ONCHIP_MEMORY_ENABLE_BIT     0

// Condition flags register fields
`define CES_CCR_I_BIT       7
`define CES_CCR_UI_BIT      6

// Vector numbers
`define CES_VEC_RESET       6'h00
`define CES_VEC_NMI         6'h07
`define CES_VEC_TRAP_BASE   6'h08
`define CES_VEC_SRC_BASE    6'h0c

// Stack frame size in bytes
`define CES_FRAME_BYTES     24'h000004

`endif

// [design/ces_pin_edge.v]
// Two-flop synchroniser with selectable edge detection.
// Assumes an asynchronous pin input; outputs are in the i_clk domain.
`timescale 1ns/1ns
`default_nettype none

module ces_pin_edge (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst,
    // Pin and edge choice
    input  wire i_pin,
    input  wire i_rise_sel,
    // Results
    output reg  o_level,
    output reg  o_edge
);

    reg meta_r;
    reg prev_r;

    // First flop feeds only the second; edges are seen one stage later
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r  <= 1'b0;
            o_level <= 1'b0;
            prev_r  <= 1'b0;
            o_edge  <= 1'b0;
        end else begin
            meta_r  <= i_pin;
            o_level <= meta_r;
            prev_r  <= o_level;
            o_edge  <= i_rise_sel ? (o_level & ~prev_r) : (~o_level & prev_r);
        end
    end

endmodule

`default_nettype wire

// [verification/ces_mem_model.sv]
// Memory responder for the sequencer's vector fetch and frame push.
// Assumes requests are held until acknowledged; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module ces_mem_model (
    // Clock and pacing
    input  wire logic        i_clk,
    input  wire logic        i_slow,
    // Request side
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [23:0] i_addr,
    // Answer side
    output var  logic        o_ack,
    output var  logic [31:0] o_rdata
);
    logic [1:0] cnt_r = 2'h0;
    initial o_ack = 1'b0;
    initial o_rdata = 32'h0;
    // Data toggle outside the ack cycle so a late capture cannot match
    always @(posedge i_clk) begin
        o_ack   <= 1'b0;
        o_rdata <= ~o_rdata;
        if ((i_rd || i_wr) && !o_ack) begin
            if (cnt_r == (i_slow ? 2'h3 : 2'h0)) begin
                o_ack   <= 1'b1;
                cnt_r   <= 2'h0;
                o_rdata <= {8'h00, i_addr + 24'h001000};
            end else begin
                cnt_r <= cnt_r + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// [verification/ces_top_properties.sv]
// Timing checks on the exception sequencer's ports.
// Assumes a bind onto ces_top; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module ces_top_properties (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // Watched ports
    input wire logic        i_chip_init_pin_n,
    input wire logic        i_watchdog_unit_ovf,
    input wire logic [23:0] i_pc,
    input wire logic [7:0]  i_condition_flags_register,
    input wire logic [23:0] i_stack_top_pointer,
    input wire logic        i_mem_ack,
    input wire logic        o_mem_rd,
    input wire logic        o_mem_wr,
    input wire logic [23:0] o_mem_addr,
    input wire logic [31:0] o_mem_wdata,
    input wire logic        o_run,
    input wire logic        o_periph_init,
    input wire logic        o_pc_load,
    input wire logic [7:0]  o_flags_new,
    input wire logic        o_sp_load,
    input wire logic [23:0] o_sp_new,
    input wire logic        o_irq_ack,
    input wire logic [5:0]  o_irq_ack_vec
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire [23:0] frame_w = (i_stack_top_pointer - 24'h000004) & 24'hfffffe;
    sequence s_pin_low;
        !i_chip_init_pin_n [*5];
    endsequence
    sequence s_rd_vec0;
        o_mem_rd && o_mem_addr == 24'h000000;
    endsequence
    init_halt_a: assert property (s_pin_low |-> o_periph_init && !o_run && !o_mem_wr)
        else $error("core not halted while init pin low");
    init_rise_a: assert property ($rose(i_chip_init_pin_n) |-> ##[1:8] s_rd_vec0)
        else $error("no reset vector fetch after init pin rise");
    req_hold_a: assert property (o_mem_rd && !i_mem_ack && i_chip_init_pin_n
        && !i_watchdog_unit_ovf |=> o_mem_rd && $stable(o_mem_addr))
        else $error("read request changed before ack");
    rd_drop_a: assert property (o_mem_rd && i_mem_ack |=> !o_mem_rd)
        else $error("read request held past ack");
    push_frame_a: assert property (o_mem_wr |-> o_mem_addr == frame_w
        && o_mem_wdata == {i_condition_flags_register, i_pc})
        else $error("frame push wrong");
    vec_slot_a: assert property (o_mem_wr && i_mem_ack |=> o_mem_rd
        && o_mem_addr[1:0] == 2'h0 && o_mem_addr < 24'h0000f4)
        else $error("vector fetch not in table");
    sp_step_a: assert property (o_sp_load |-> o_sp_new == frame_w)
        else $error("stack pointer not lowered by four");
    load_mask_a: assert property (o_pc_load |-> o_run && o_flags_new[7] && !o_mem_rd)
        else $error("entry ended without global mask");
    ack_entry_a: assert property (o_irq_ack |-> o_mem_wr && !o_run
        && (o_irq_ack_vec == 6'h07 || o_irq_ack_vec >= 6'h0c))
        else $error("interrupt ack without frame push");
endmodule
bind ces_top ces_top_properties u_ces_top_properties (.*);
`default_nettype wire

// [verification/ces_top_tb.sv]
// Self-checking bench for the exception sequencer.
// Assumes ces_mem_model answers the memory port.
`timescale 1ns/1ns
`default_nettype none
module ces_top_tb;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        pin_n = 1'b0, nmi = 1'b1, ovf = 1'b0, wsel = 1'b1, m16 = 1'b0;
    logic        done = 1'b0, trap = 1'b0, slow = 1'b0, rwr = 1'b0, rrd = 1'b0;
    logic [41:0] irq = 42'h0;
    logic [1:0]  tsel = 2'h0;
    logic [7:0]  flg = 8'h00, ra = 8'h00, rwd = 8'h00;
    logic [23:0] acc = 24'h0, ma, wa;
    logic [31:0] wd;
    logic [5:0]  av;
    wire         ack, rd, wr, run, init, pcl, fll, spl, iack, ext;
    wire  [31:0] rdat, wdat;
    wire  [23:0] addr, pcn, spn;
    wire  [7:0]  fln, rdo;
    wire  [5:0]  ivec;
    wire  [2:0]  area;
    int          nw = 0, na = 0, w0, err_count = 0, checks = 0;
    always #2 i_clk = ~i_clk;
    ces_top u_ces_top (
        .i_clk(i_clk), .i_rst(i_rst), .i_chip_init_pin_n(pin_n), .i_nmi_pin(nmi),
        .i_mode_16m_pin(m16), .i_watchdog_unit_ovf(ovf), .i_watchdog_unit_rst_sel(wsel),
        .i_irq_req(irq), .i_insn_done(done), .i_software_trap_instruction(trap),
        .i_trap_sel(tsel), .i_pc(24'h002468), .i_condition_flags_register(flg),
        .i_stack_top_pointer(24'h00fff0), .i_mem_ack(ack), .i_mem_rdata(rdat),
        .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_addr(addr), .o_mem_wdata(wdat),
        .o_run(run), .o_periph_init(init), .o_pc_load(pcl), .o_pc_new(pcn),
        .o_flags_load(fll), .o_flags_new(fln), .o_sp_load(spl), .o_sp_new(spn),
        .o_irq_ack(iack), .o_irq_ack_vec(ivec), .i_acc_addr(acc), .o_area(area),
        .o_ext_bus(ext), .i_reg_addr(ra), .i_reg_wdata(rwd), .i_reg_wr(rwr),
        .i_reg_rd(rrd), .o_reg_rdata(rdo));
    ces_mem_model u_ces_mem_model (.i_clk(i_clk), .i_slow(slow), .i_rd(rd), .i_wr(wr),
        .i_addr(addr), .o_ack(ack), .o_rdata(rdat));
    always @(posedge i_clk) begin
        if (ack && rd) ma <= addr;
        if (ack && wr) begin
            wa <= addr;
            wd <= wdat;
            nw <= nw + 1;
        end
        if (iack) begin
            av <= ivec;
            na <= na + 1;
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        rwr <= 1'b1; ra <= a; rwd <= d;
        @(posedge i_clk);
        rwr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        rrd <= 1'b1; ra <= a;
        @(posedge i_clk);
        rrd <= 1'b0;
        #1 chk(rdo, e);
    endtask
    // Waits for the entry to end; the fetched slot gives the new PC
    task automatic entry(input logic [23:0] era, input logic [7:0] efl);
        int k;
        k = 0;
        while (pcl !== 1'b1 && k < 80) begin
            @(posedge i_clk);
            #1 k++;
        end
        chk(ma, era); chk(pcn, era + 24'h001000); chk(fln, efl); chk(run, 1'b1);
        chk({pcl, fll}, 2'h3);
        @(posedge i_clk);
    endtask
    task automatic pulse_done();
        @(posedge i_clk) done <= 1'b1;
        @(posedge i_clk) done <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #40000 err_count++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        irq[4:2] <= 3'h7;
        repeat (10) @(posedge i_clk);
        pin_n <= 1'b1;
        entry(24'h000000, 8'h80);
        chk(nw, 0);
        reg_rd(8'hf2, 8'h0b);
        reg_rd(8'hf9, 8'h00);
        reg_rd(8'h77, 8'h00);
        reg_wr(8'hf8, 8'h10);
        reg_rd(8'hf8, 8'h10);
        pulse_done();
        repeat (20) @(posedge i_clk);
        chk(na, 0);
        slow <= 1'b1;
        pulse_done();
        @(posedge i_clk) irq[4:2] <= 3'h0;
        entry(24'h000040, 8'h80);
        chk(av, 6'h10);
        chk(wa, 24'h00ffec); chk(wd, 32'h00002468);
        flg <= 8'h80;
        for (int s = 0; s < 4; s++) begin
            reg_wr(8'hf2, {4'h0, s[0], 3'h3});
            @(posedge i_clk) trap <= 1'b1;
            tsel <= s[1:0];
            @(posedge i_clk) trap <= 1'b0;
            entry(24'h000020 + 24'(s * 4), s[0] ? 8'h80 : 8'hc0);
        end
        irq[0] <= 1'b1;
        nmi <= 1'b0;
        repeat (4) @(posedge i_clk);
        pulse_done();
        entry(24'h00001c, 8'h80);
        chk(av, 6'h07);
        repeat (10) @(posedge i_clk);
        chk(na, 2);
        irq[0] <= 1'b0;
        reg_wr(8'hf2, 8'h0a);
        acc <= 24'h0fef10;
        repeat (3) @(posedge i_clk);
        #1 chk({area, ext}, {3'h7, 1'b1});
        @(posedge i_clk) pin_n <= 1'b0;
        repeat (10) @(posedge i_clk);
        pin_n <= 1'b1;
        entry(24'h000000, 8'h80);
        reg_rd(8'hf2, 8'h0b);
        #1 chk(ext, 1'b0);
        @(posedge i_clk) m16 <= 1'b1;
        repeat (4) @(posedge i_clk);
        #1 chk({area, ext}, {3'h0, 1'b1});
        w0 = nw;
        @(posedge i_clk) ovf <= 1'b1;
        @(posedge i_clk) ovf <= 1'b0;
        entry(24'h000000, 8'h80);
        chk(nw, w0);
        reg_wr(8'hf2, 8'h0f);
        pulse_done();
        nmi <= 1'b1;
        repeat (4) @(posedge i_clk);
        pulse_done();
        entry(24'h00001c, 8'h80);
        print_verdict();
    end
endmodule
`default_nettype wire
